// ===== pkg/tpg_defs.svh
// Register indices, field positions, reset values and widths of the lane test pattern generator.
// Assumes inclusion by bare name; definitions only.
`ifndef TPG_DEFS_SVH
`define TPG_DEFS_SVH

// Register indices; byte address is four times the index
`define TPG_IDX_CTRL 8'h10
`define TPG_IDX_RSVD 8'h11
`define TPG_IDX_SEED_LOW_01 8'h12
`define TPG_IDX_SEED_LOW_23 8'h13
`define TPG_IDX_SEED_LOW_45 8'h14
`define TPG_IDX_SEED_LOW_67 8'h15
`define TPG_IDX_SEED_HIGH 8'h16
`define TPG_IDX_STATUS 8'h17

// Control field positions
`define TPG_CTRL_PATTERN_EN 0
`define TPG_CTRL_INC_PATTERN 1
`define TPG_CTRL_SEQ_EN 2
`define TPG_CTRL_FRAME_PATTERN 3

// Reset values
`define TPG_RST_CTRL 4'h0
`define TPG_RST_RSVD 16'h0000
`define TPG_RST_SEED_LOW_01 16'h0100
`define TPG_RST_SEED_LOW_23 16'h0302
`define TPG_RST_SEED_LOW_45 16'h0504
`define TPG_RST_SEED_LOW_67 16'h0706
`define TPG_RST_SEED_HIGH 16'h0000

// Datapath geometry
`define TPG_WORD_W 10
`define TPG_LANES 32
`define TPG_GROUPS 8
`define TPG_WORD_MAX 10'h3ff
`define TPG_IDX_W 8
`define TPG_ADDR_W 12

`endif

// ===== pkg/tpg_pkg.sv
// Types shared by the lane test pattern generator and its group counter.
// Assumes tpg_defs.svh is on the include path.
`include "tpg_defs.svh"

package tpg_pkg;
    typedef logic [`TPG_WORD_W-1:0] tpg_word_type;
    typedef logic [`TPG_LANES-1:0][`TPG_WORD_W-1:0] tpg_lanes_type;

    typedef struct packed {
        logic frame_pattern;
        logic seq_en;
        logic inc_pattern;
        logic pattern_en;
    } tpg_ctrl_type;

    // One sample slot across all datapaths
    typedef struct packed {
        logic valid;
        logic frame;
        tpg_lanes_type data;
    } tpg_sample_type;
endpackage

// ===== core/tpg_group_counter.sv
// Per-group pattern word: constant seed or counting from seed up to the top word.
// Assumes seed and controls come from registers in the same clock domain.
`timescale 1ns/1ps
`include "tpg_defs.svh"

module tpg_group_counter (
    input wire logic pclk, // Clock
    input wire logic presetn, // Asynchronous reset, active low
    input wire tpg_pkg::tpg_word_type seed, // Configured start word
    input wire logic count_en, // Counting mode selected
    input wire logic run, // Pattern enabled
    input wire logic step, // Advance one word
    output tpg_pkg::tpg_word_type word // Current pattern word
);
    import tpg_pkg::*;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word <= '0;
        end else if (!run || !count_en) begin
            // Constant mode tracks the seed so rewrites show at once
            word <= seed;
        end else if (step) begin
            if (word == `TPG_WORD_MAX) begin
                word <= seed;
            end else begin
                word <= word + 10'h001;
            end
        end
    end
endmodule

// ===== core/tpg_lane_pattern_gen.sv
// Lane test pattern generator: APB register file and 32-lane pattern substitution.
// Assumes an APB master on pclk and sample slots from the readout synchronous to pclk.
`timescale 1ns/1ps
`include "tpg_defs.svh"

// Operation
// - Inc select one gives incrementing words; zero, with sequence enable also zero, gives the constant seed word.
// - Sequence enable one also counts per datapath, starting at the group seed.
// - Counter climbs to 1023, then reloads its seed on the next word.
// - Frame select one keeps frame structure; zero sends patterns unframed.
// - Group 0 drives lanes 0,8,16,24; low byte from first seed register [7:0].
// - Group 1 drives lanes 1,9,17,25; low byte from first seed register [15:8].
// - Group 2 drives lanes 2,10,18,26; low byte from second seed register [7:0].
// - Group 3 drives lanes 3,11,19,27; low byte from second seed register [15:8].
// - Group 4 drives lanes 4,12,20,28; low byte from third seed register [7:0].
// - Group 5 drives lanes 5,13,21,29; low byte from third seed register [15:8].
// - Group 6 drives lanes 6,14,22,30; low byte from fourth seed register [7:0].
// - Full seed joins the low byte with two high bits from the high-seed register.
// - Patterns replace normal output only while master enable is one.
// - High-seed register holds two bits per group, group 0 at [1:0].
module tpg_lane_pattern_gen (
    input wire logic pclk, // Clock, 20 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [`TPG_ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic pready, // APB ready
    output logic [31:0] prdata, // APB read data
    output logic pslverr, // APB error on unmapped address
    input wire tpg_pkg::tpg_sample_type pix_in, // Normal image samples
    output tpg_pkg::tpg_sample_type pix_out // Samples toward the serialisers
);
    import tpg_pkg::*;

    tpg_ctrl_type ctrl;
    logic [15:0] rsvd_word;
    logic [3:0][15:0] seed_low;
    logic [15:0] seed_high;
    // Nets, since each element has its own driver in the generate loops
    wire tpg_word_type [`TPG_GROUPS-1:0] seed;
    wire tpg_word_type [`TPG_GROUPS-1:0] group_word;
    wire tpg_lanes_type next_lane;
    logic [`TPG_IDX_W-1:0] idx;
    logic access;
    logic wr_fire;
    logic hit;
    logic step;
    logic [15:0] next_rdata;
    logic [15:0] wmask;

    assign idx = paddr[`TPG_IDX_W+1:2];
    assign access = psel && penable;
    assign wr_fire = access && pready && pwrite;
    assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    always_comb begin
        hit = 1'b1;
        case (idx)
            `TPG_IDX_CTRL: hit = 1'b1;
            `TPG_IDX_RSVD: hit = 1'b1;
            `TPG_IDX_SEED_LOW_01: hit = 1'b1;
            `TPG_IDX_SEED_LOW_23: hit = 1'b1;
            `TPG_IDX_SEED_LOW_45: hit = 1'b1;
            `TPG_IDX_SEED_LOW_67: hit = 1'b1;
            `TPG_IDX_SEED_HIGH: hit = 1'b1;
            `TPG_IDX_STATUS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        // Unaligned byte offsets are not mapped
        if (paddr[1:0] != 2'b00) begin
            hit = 1'b0;
        end
    end

    always_comb begin
        next_rdata = 16'h0000;
        case (idx)
            `TPG_IDX_CTRL: next_rdata = {12'h000, ctrl};
            `TPG_IDX_RSVD: next_rdata = rsvd_word;
            `TPG_IDX_SEED_LOW_01: next_rdata = seed_low[0];
            `TPG_IDX_SEED_LOW_23: next_rdata = seed_low[1];
            `TPG_IDX_SEED_LOW_45: next_rdata = seed_low[2];
            `TPG_IDX_SEED_LOW_67: next_rdata = seed_low[3];
            `TPG_IDX_SEED_HIGH: next_rdata = seed_high;
            `TPG_IDX_STATUS: next_rdata = {ctrl.pattern_en, 5'h00, group_word[0]};
            default: next_rdata = 16'h0000;
        endcase
    end

    // One wait state: pready rises on the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= access && !pready;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (access && !pready) begin
            prdata <= (!pwrite && hit) ? {16'h0000, next_rdata} : 32'h0000_0000;
            pslverr <= !hit;
        end else begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `TPG_RST_CTRL;
        end else if (wr_fire && hit && idx == `TPG_IDX_CTRL && pstrb[0]) begin
            // Bit 4 is reserved and reads as zero
            ctrl <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsvd_word <= `TPG_RST_RSVD;
        end else if (wr_fire && hit && idx == `TPG_IDX_RSVD) begin
            rsvd_word <= (rsvd_word & ~wmask) | (pwdata[15:0] & wmask);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seed_low[0] <= `TPG_RST_SEED_LOW_01;
            seed_low[1] <= `TPG_RST_SEED_LOW_23;
            seed_low[2] <= `TPG_RST_SEED_LOW_45;
            seed_low[3] <= `TPG_RST_SEED_LOW_67;
        end else if (wr_fire && hit) begin
            case (idx)
                `TPG_IDX_SEED_LOW_01: seed_low[0] <= (seed_low[0] & ~wmask) | (pwdata[15:0] & wmask);
                `TPG_IDX_SEED_LOW_23: seed_low[1] <= (seed_low[1] & ~wmask) | (pwdata[15:0] & wmask);
                `TPG_IDX_SEED_LOW_45: seed_low[2] <= (seed_low[2] & ~wmask) | (pwdata[15:0] & wmask);
                `TPG_IDX_SEED_LOW_67: seed_low[3] <= (seed_low[3] & ~wmask) | (pwdata[15:0] & wmask);
                default: seed_low <= seed_low;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seed_high <= `TPG_RST_SEED_HIGH;
        end else if (wr_fire && hit && idx == `TPG_IDX_SEED_HIGH) begin
            seed_high <= (seed_high & ~wmask) | (pwdata[15:0] & wmask);
        end
    end

    // Framed patterns advance only inside the readout's frame windows
    assign step = pix_in.valid && (!ctrl.frame_pattern || pix_in.frame);

    genvar g;
    generate
        for (g = 0; g < `TPG_GROUPS; g = g + 1) begin : gen_group
            // Even groups take the low byte, odd groups the high byte
            assign seed[g] = {seed_high[2*g+1 -: 2], seed_low[g/2][8*(g%2)+7 -: 8]};

            tpg_group_counter u_counter (
                .pclk(pclk),
                .presetn(presetn),
                .seed(seed[g]),
                .count_en(ctrl.inc_pattern || ctrl.seq_en),
                .run(ctrl.pattern_en),
                .step(step),
                .word(group_word[g])
            );
        end
    endgenerate

    genvar l;
    generate
        for (l = 0; l < `TPG_LANES; l = l + 1) begin : gen_lane
            // Word sits in the pixel slot of its lane
            assign next_lane[l] = ctrl.pattern_en ? group_word[l % `TPG_GROUPS] : pix_in.data[l];
        end
    endgenerate

    // One process owns the whole output struct
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pix_out <= '0;
        end else begin
            pix_out.data <= next_lane;
            pix_out.valid <= pix_in.valid;
            // Unframed patterns carry no frame marking
            pix_out.frame <= pix_in.frame && (!ctrl.pattern_en || ctrl.frame_pattern);
        end
    end
endmodule

// ===== verif/tpg_lane_pattern_gen_properties.sv
// Port checks for the lane test pattern generator.
// Assumes one clock domain on pclk and the async reset presetn.
`timescale 1ns/1ps
module tpg_chk (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, low
    input wire logic psel, // Select
    input wire logic penable, // Access
    input wire logic pwrite, // Direction
    input wire logic [11:0] paddr, // Address
    input wire logic pready, // Ready
    input wire logic [31:0] prdata, // Read data
    input wire logic pslverr, // Error
    input wire tpg_pkg::tpg_sample_type pix_in, // Samples in
    input wire tpg_pkg::tpg_sample_type pix_out // Samples out
);
    import tpg_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s; psel && !penable; endsequence
    sequence wait_s; psel && penable && !pready; endsequence
    one_wait_a: assert property (setup_s ##1 wait_s |=> pready)
        else $error("late ready");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("long ready");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("stray ready");
    rdata_idle_a: assert property (!pready || pwrite |-> prdata == 32'h0)
        else $error("stray read data");
    rdata_upper_a: assert property (prdata[31:16] == 16'h0)
        else $error("upper read data");
    unmapped_err_a: assert property (pready && !(paddr[9:2] inside {[8'h10:8'h17]}) |-> pslverr)
        else $error("no error");
    mapped_ok_a: assert property (pready && paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0
        && paddr[9:2] inside {[8'h10:8'h17]} |-> !pslverr) else $error("false error");
    valid_delay_a: assert property (1'b1 |=> pix_out.valid == $past(pix_in.valid))
        else $error("slot lost");
    frame_gate_a: assert property (!pix_in.frame |=> !pix_out.frame)
        else $error("stray frame");
    group_copy_a: assert property (pix_out.valid && pix_out.data != $past(pix_in.data)
        |-> pix_out.data[31:8] == {3{pix_out.data[7:0]}}) else $error("lane group split");
endmodule
bind tpg_lane_pattern_gen tpg_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pix_in(pix_in), .pix_out(pix_out));

// ===== verif/tpg_rx_model.sv
// Receiver model: every lane must match the first lane of its group.
// Assumes check is high only while patterns are expected.
`timescale 1ns/1ps
module tpg_rx_model (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, low
    input wire logic check, // Patterns expected
    input wire tpg_pkg::tpg_sample_type smp, // Incoming samples
    output logic [7:0] n_bad // Misaligned samples
);
    import tpg_pkg::*;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n_bad <= 8'h0;
        end else if (check && smp.valid && smp.data[31:8] !== {3{smp.data[7:0]}}) begin
            n_bad <= n_bad + 8'h1;
        end
    end
endmodule

// ===== verif/tb.sv
// Self-checking bench for the lane test pattern generator.
// Assumes design, checker and receiver model compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; $display("wrong value at %0t", $time); end end
module tb;
    import tpg_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, check = 0, pready, pslverr;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [7:0] n_bad;
    tpg_sample_type pix_in = '0, pix_out;
    logic [32:0] rq[$];
    tpg_sample_type pq[$];
    tpg_word_type sd[8], cn[8];
    int n_fail = 0, cmp_count = 0, cyc = 0;
    initial forever #25 pclk = ~pclk;
    tpg_lane_pattern_gen i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .pix_in(pix_in), .pix_out(pix_out));
    tpg_rx_model i_rx (.pclk(pclk), .presetn(presetn), .check(check), .smp(pix_out), .n_bad(n_bad));
    always @(posedge pclk) begin
        cyc++;
        if (pready) `CHK({pslverr, prdata}, rq.pop_front())
        if (pix_out.valid) `CHK(pix_out, pq.pop_front())
        if (cyc > 3000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic apb(input logic w, input logic [7:0] idx, input logic [15:0] d, input logic [32:0] x);
        rq.push_back(x);
        psel <= 1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {16'($urandom), d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic seeds(input logic [15:0] hi, input logic [15:0] f);
        logic [15:0] lo;
        for (int g = 0; g < 8; g += 2) begin
            lo = 16'($urandom) | f;
            apb(1, 8'h12 + 8'(g / 2), lo, 33'h0);
            sd[g] = {hi[2 * g +: 2], lo[7:0]};
            sd[g + 1] = {hi[2 * g + 2 +: 2], lo[15:8]};
        end
        apb(1, 8'h16, hi, 33'h0);
        apb(0, 8'h16, 16'h0, {17'h0, hi});
    endtask
    task automatic px(input logic fr, input logic [3:0] c);
        tpg_sample_type s, e;
        s = '0;
        s.valid = 1;
        s.frame = fr;
        for (int l = 0; l < 32; l++) s.data[l] = 10'($urandom);
        e = s;
        if (c[0]) e.frame = fr & c[3];
        for (int l = 0; l < 32; l++) if (c[0]) e.data[l] = cn[l % 8];
        for (int g = 0; g < 8; g++) if (c[0] && c[2:1] != 2'h0 && (fr || !c[3]))
            cn[g] = cn[g] == 10'h3ff ? sd[g] : cn[g] + 10'h1;
        pq.push_back(e);
        pix_in <= s;
        @(posedge pclk);
    endtask
    task automatic run(input logic [3:0] c, input int n);
        apb(1, 8'h10, 16'h0, 33'h0);
        cn = sd;
        apb(1, 8'h10, {12'h0, c}, 33'h0);
        check <= c[0];
        repeat (n) px(1'($urandom), c);
        pix_in <= '0;
        repeat (2) @(posedge pclk);
        $display("test mode %h done", c);
    endtask
    initial begin
        logic [15:0] rst[8] = '{16'h0, 16'h0, 16'h0100, 16'h0302, 16'h0504, 16'h0706, 16'h0, 16'h0};
        void'($urandom(32'h808decf6));
        repeat (12) @(posedge pclk);
        presetn <= 1;
        for (int i = 0; i < 8; i++) apb(0, 8'h10 + 8'(i), 16'h0, {17'h0, rst[i]});
        apb(0, 8'h20, 16'h0, {1'b1, 32'h0});
        apb(1, 8'h08, 16'hffff, {1'b1, 32'h0});
        $display("test registers done");
        run(4'h0, 4);
        seeds(16'($urandom), 16'h0);
        run(4'h9, 3);
        run(4'h1, 3);
        seeds(16'hffff, 16'hfcfc);
        run(4'hb, 10);
        run(4'hd, 10);
        run(4'h3, 10);
        `CHK(n_bad, 8'h0)
        end_of_test();
    end
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
endmodule
